// file: shared/spfc_defines.svh
/*
 Constants of the self-programming flash controller: control bit positions,
 command patterns, timing windows and host register offsets.
 Assumes inclusion by bare name from every file that needs them.
*/
`ifndef SPFC_DEFINES_SVH
`define SPFC_DEFINES_SVH

`define SPFC_CLK_NS 10
`define SPFC_OP_MIN_NS 3700000
`define SPFC_PAGE_WORDS 32
`define SPFC_PAGES 16

`define SPFC_BIT_ARM 0
`define SPFC_BIT_ERASE 1
`define SPFC_BIT_WRITE 2
`define SPFC_BIT_FUSE_LOCK_READ_BIT 3
`define SPFC_BIT_CLEAR_PAGE_BUFFER_BIT 4

`define SPFC_CMD_LOAD 5'h01
`define SPFC_CMD_ERASE 5'h03
`define SPFC_CMD_WRITE 5'h05
`define SPFC_CMD_FUSE_LOCK_READ_BIT 5'h09
`define SPFC_CMD_CLEAR_PAGE_BUFFER_BIT 5'h11

`define SPFC_SPM_WINDOW 3'h4
`define SPFC_LPM_WINDOW 2'h3
`define SPFC_ERASED_WORD 16'hffff

`define SPFC_SEL_FUSE_LOW 2'h0
`define SPFC_SEL_LOCK 2'h1
`define SPFC_SEL_FUSE_HIGH 2'h3

`define SPFC_REG_Z 3'h0
`define SPFC_REG_DATA 3'h1
`define SPFC_REG_CTRL 3'h2
`define SPFC_REG_GO 3'h3
`define SPFC_REG_STATUS 3'h4
`define SPFC_REG_RESULT 3'h5
`define SPFC_GO_SPM 0
`define SPFC_GO_LPM 1

`endif

// file: shared/spfc_pkg.sv
/*
 Types used by the flash controller end of the self-programming flash controller.
 Assumes nothing of its surroundings.
*/
`default_nettype none
package spfc_pkg;
  typedef enum logic [2:0] {
    SPFC_IDLE = 3'h1,
    SPFC_ERASE = 3'h2,
    SPFC_WRITE = 3'h4
  } spfc_state_e;
endpackage : spfc_pkg
`default_nettype wire

// file: shared/spfc_if.sv
/*
 Link between the processor core end and the flash controller end.
 Assumes both ends run on the same system clock.
*/
`timescale 1ns/10ps
`default_nettype none
interface spfc_if;
  logic ctrl_wr;
  logic [7:0] ctrl_wdata;
  logic [7:0] ctrl_rdata;
  logic store_program_instr;
  logic load_program_instr;
  logic [15:0] z_ptr;
  logic [15:0] write_data_pair;
  logic stall;
  logic lpm_valid;
  logic [7:0] lpm_data;
  modport device (input ctrl_wr, ctrl_wdata, store_program_instr, load_program_instr, z_ptr, write_data_pair,
                  output ctrl_rdata, stall, lpm_valid, lpm_data);
  modport core (output ctrl_wr, ctrl_wdata, store_program_instr, load_program_instr, z_ptr, write_data_pair,
                input ctrl_rdata, stall, lpm_valid, lpm_data);
endinterface : spfc_if
`default_nettype wire

// file: logic/spfc_device.sv
/*
 Flash controller end: control register, temporary page buffer, page erase
 and page write into a small flash array, program and fuse/lock reads.
 Assumes a core end that pulses store/load requests and obeys the stall.
*/
// Overview of operation
// - Erase pattern then store within four cycles
// - Erase uses page field only
// - Core stalled through whole erase
// - Load pattern then store loads buffer word
// - Buffer slot from word field
// - Buffer clears after write, clear bit, reset
// - Software loads each slot once between clears
// - EEPROM write discards partly loaded buffer
// - Write pattern then store programs page
// - Software zeroes non-page bits for write
// - Core stalled through whole write
// - Lowest pointer bit selects read byte
// - Upper three control bits read zero
// - Clear bit empties buffer
// - Fuse/lock read within three cycles
// - Same page for erase and write
// - Erase before write; fill anytime
// - Buffer loads in any order
// - Low bits word, high bits page
// - Write bit self-clears on done/timeout
// - Erase bit self-clears on done/timeout
// - Arm lasts four cycles (three for fuse/lock read), holds during op
// - Other command patterns ignored
`timescale 1ns/10ps
`default_nettype none
`include "spfc_defines.svh"
module spfc_device #(
  parameter int PAGE_WORDS = `SPFC_PAGE_WORDS,
  parameter int PAGES = `SPFC_PAGES,
  parameter int OP_CYCLES = (`SPFC_OP_MIN_NS + `SPFC_CLK_NS - 1) / `SPFC_CLK_NS
) (
  input wire logic sys_clk_i, // System clock
  input wire logic rstn_i, // Synchronous reset, active low
  spfc_if.device bus, // Core side
  input wire logic eeprom_busy_i, // EEPROM write in progress
  input wire logic [7:0] fuse_low_i, // Fuse low byte
  input wire logic [7:0] fuse_high_i, // Fuse high byte
  input wire logic [7:0] lock_bits_i, // Lock bits
  output logic busy_o // Erase or write in progress
);
  localparam int WB = $clog2(PAGE_WORDS);
  localparam int PB = $clog2(PAGES);

  typedef struct packed {
    spfc_pkg::spfc_state_e st;
    logic arm;
    logic erase;
    logic write;
    logic fuse_lock_read_bit;
    logic [2:0] spm_win;
    logic [1:0] lpm_win;
    logic [31:0] timer;
    logic [PB-1:0] op_page;
    logic [PAGE_WORDS-1:0] buf_vld;
    logic [PAGE_WORDS-1:0][15:0] buf_dat;
    logic [PAGES*PAGE_WORDS-1:0][15:0] flash;
    logic stall;
    logic lpm_valid;
    logic [7:0] lpm_data;
    logic [7:0] ctrl_rd;
    logic busy;
  } spfc_dev_s;

  spfc_dev_s r;
  spfc_dev_s n;
  spfc_dev_s rst_v;

  function automatic logic [WB-1:0] word_of(input logic [15:0] z);
    word_of = z[WB:1];
  endfunction : word_of

  function automatic logic [PB-1:0] page_of(input logic [15:0] z);
    page_of = z[WB+PB:WB+1];
  endfunction : page_of

  function automatic logic legal_cmd(input logic [4:0] c);
    legal_cmd = (c == `SPFC_CMD_LOAD) || (c == `SPFC_CMD_ERASE) || (c == `SPFC_CMD_WRITE) ||
                (c == `SPFC_CMD_FUSE_LOCK_READ_BIT) || (c == `SPFC_CMD_CLEAR_PAGE_BUFFER_BIT);
  endfunction : legal_cmd

  always_comb begin
    logic [4:0] cmd;
    logic [15:0] word;
    int base;
    cmd = bus.ctrl_wdata[4:0];
    word = '0;
    base = 0;
    n = r;
    n.lpm_valid = 1'b0;
    unique case (r.st)
      spfc_pkg::SPFC_IDLE: begin
        if (bus.ctrl_wr && !eeprom_busy_i && legal_cmd(cmd)) begin
          if (cmd == `SPFC_CMD_CLEAR_PAGE_BUFFER_BIT) begin
            n.buf_vld = '0;
            n.arm = 1'b0;
            n.erase = 1'b0;
            n.write = 1'b0;
            n.fuse_lock_read_bit = 1'b0;
          end else begin
            n.arm = 1'b1;
            n.erase = cmd[`SPFC_BIT_ERASE];
            n.write = cmd[`SPFC_BIT_WRITE];
            n.fuse_lock_read_bit = cmd[`SPFC_BIT_FUSE_LOCK_READ_BIT];
            n.spm_win = `SPFC_SPM_WINDOW;
            n.lpm_win = `SPFC_LPM_WINDOW;
          end
        end else if (r.arm && bus.store_program_instr && r.spm_win != 3'h0) begin
          n.arm = 1'b0;
          n.fuse_lock_read_bit = 1'b0;
          n.spm_win = 3'h0;
          n.lpm_win = 2'h0;
          if (r.erase || r.write) begin
            // Arm and command bit stay up until the timer runs out
            n.arm = 1'b1;
            n.st = r.erase ? spfc_pkg::SPFC_ERASE : spfc_pkg::SPFC_WRITE;
            n.op_page = page_of(bus.z_ptr);
            n.timer = 32'(OP_CYCLES - 1);
            n.stall = 1'b1;
            n.busy = 1'b1;
          end else if (!r.fuse_lock_read_bit) begin
            n.buf_dat[word_of(bus.z_ptr)] = bus.write_data_pair;
            n.buf_vld[word_of(bus.z_ptr)] = 1'b1;
          end
        end else if (r.arm && r.fuse_lock_read_bit && bus.load_program_instr && r.lpm_win != 2'h0) begin
          n.arm = 1'b0;
          n.fuse_lock_read_bit = 1'b0;
          n.spm_win = 3'h0;
          n.lpm_win = 2'h0;
          n.lpm_valid = 1'b1;
          unique case (bus.z_ptr[1:0])
            `SPFC_SEL_LOCK: n.lpm_data = lock_bits_i;
            `SPFC_SEL_FUSE_HIGH: n.lpm_data = fuse_high_i;
            default: n.lpm_data = fuse_low_i;
          endcase
        end else if (r.arm) begin
          if (r.spm_win != 3'h0) begin
            n.spm_win = r.spm_win - 3'h1;
          end
          if (r.lpm_win != 2'h0) begin
            n.lpm_win = r.lpm_win - 2'h1;
          end
          // Read arming dies with its shorter window; others with the store window
          if ((r.fuse_lock_read_bit && r.lpm_win <= 2'h1) || r.spm_win <= 3'h1) begin
            n.arm = 1'b0;
            n.erase = 1'b0;
            n.write = 1'b0;
            n.fuse_lock_read_bit = 1'b0;
            n.spm_win = 3'h0;
            n.lpm_win = 2'h0;
          end
        end
        if (bus.load_program_instr && !n.lpm_valid) begin
          word = r.flash[{page_of(bus.z_ptr), word_of(bus.z_ptr)}];
          n.lpm_data = bus.z_ptr[0] ? word[15:8] : word[7:0];
          n.lpm_valid = 1'b1;
        end
      end
      spfc_pkg::SPFC_ERASE, spfc_pkg::SPFC_WRITE: begin
        if (r.timer != 32'h0) begin
          n.timer = r.timer - 32'h1;
        end else begin
          base = int'(r.op_page) * PAGE_WORDS;
          for (int i = 0; i < PAGE_WORDS; i++) begin
            if (r.st == spfc_pkg::SPFC_ERASE) begin
              n.flash[base + i] = `SPFC_ERASED_WORD;
            end else if (r.buf_vld[i]) begin
              // Programming can only clear bits of an erased word
              n.flash[base + i] = r.flash[base + i] & r.buf_dat[i];
            end
          end
          if (r.st == spfc_pkg::SPFC_WRITE) begin
            n.buf_vld = '0;
          end
          n.st = spfc_pkg::SPFC_IDLE;
          n.arm = 1'b0;
          n.erase = 1'b0;
          n.write = 1'b0;
          n.stall = 1'b0;
          n.busy = 1'b0;
        end
      end
    endcase
    if (eeprom_busy_i) begin
      n.buf_vld = '0;
    end
    n.ctrl_rd = 8'h00;
    n.ctrl_rd[`SPFC_BIT_ARM] = n.arm;
    n.ctrl_rd[`SPFC_BIT_ERASE] = n.erase;
    n.ctrl_rd[`SPFC_BIT_WRITE] = n.write;
    n.ctrl_rd[`SPFC_BIT_FUSE_LOCK_READ_BIT] = n.fuse_lock_read_bit;
  end

  always_comb begin
    rst_v = '0;
    rst_v.st = spfc_pkg::SPFC_IDLE;
    rst_v.flash = r.flash; // Flash contents survive reset; the buffer does not
  end

  always_ff @(posedge sys_clk_i) begin
    r <= rstn_i ? n : rst_v;
  end

  assign bus.ctrl_rdata = r.ctrl_rd;
  assign bus.stall = r.stall;
  assign bus.lpm_valid = r.lpm_valid;
  assign bus.lpm_data = r.lpm_data;
  assign busy_o = r.busy;
endmodule : spfc_device
`default_nettype wire

// file: logic/spfc_host.sv
/*
 Processor core end: software registers holding pointer, data and command,
 issuing control writes and store/load requests to the flash controller.
 Assumes a plain register port with read data one cycle after the strobe.
*/
`timescale 1ns/10ps
`default_nettype none
`include "spfc_defines.svh"
module spfc_host #(
  parameter int PAGE_WORDS = `SPFC_PAGE_WORDS,
  parameter int PAGES = `SPFC_PAGES
) (
  input wire logic sys_clk_i, // System clock
  input wire logic rstn_i, // Synchronous reset, active low
  input wire logic [2:0] addr_i, // Register address
  input wire logic [15:0] wdata_i, // Write data
  input wire logic wr_i, // Write strobe
  input wire logic rd_i, // Read strobe
  output logic [15:0] rdata_o, // Read data, cycle after strobe
  spfc_if.core bus // Controller side
);
  localparam int WB = $clog2(PAGE_WORDS);
  localparam int PB = $clog2(PAGES);

  typedef struct packed {
    logic [15:0] z;
    logic [15:0] pair;
    logic [4:0] last_cmd;
    logic ctrl_wr;
    logic [7:0] ctrl_wdata;
    logic store_program_instr;
    logic load_program_instr;
    logic [15:0] z_out;
    logic [PAGE_WORDS-1:0] loaded;
    logic [PB-1:0] erased_page;
    logic erased_vld;
    logic refused;
    logic [7:0] result;
    logic [15:0] rdata;
  } spfc_host_s;

  spfc_host_s r;
  spfc_host_s n;

  function automatic logic [PB-1:0] page_of(input logic [15:0] z);
    page_of = z[WB+PB:WB+1];
  endfunction : page_of

  always_comb begin
    logic [WB-1:0] w;
    logic refuse;
    w = r.z[WB:1];
    refuse = 1'b0;
    n = r;
    n.ctrl_wr = 1'b0;
    n.store_program_instr = 1'b0;
    n.load_program_instr = 1'b0;
    n.rdata = 16'h0000;
    if (bus.lpm_valid) begin
      n.result = bus.lpm_data;
    end
    if (rd_i) begin
      unique case (addr_i)
        `SPFC_REG_Z: n.rdata = r.z;
        `SPFC_REG_DATA: n.rdata = r.pair;
        `SPFC_REG_STATUS: begin
          n.rdata = {6'h00, r.refused, bus.stall, bus.ctrl_rdata};
          n.refused = 1'b0;
        end
        `SPFC_REG_RESULT: n.rdata = {8'h00, r.result};
        default: n.rdata = 16'h0000;
      endcase
    end
    if (wr_i) begin
      unique case (addr_i)
        `SPFC_REG_Z: n.z = wdata_i;
        `SPFC_REG_DATA: n.pair = wdata_i;
        `SPFC_REG_CTRL: begin
          n.ctrl_wr = !bus.stall;
          n.ctrl_wdata = wdata_i[7:0];
          n.last_cmd = wdata_i[4:0];
          refuse = bus.stall;
          if (!bus.stall && wdata_i[4:0] == `SPFC_CMD_CLEAR_PAGE_BUFFER_BIT) begin
            n.loaded = '0;
          end
        end
        `SPFC_REG_GO: begin
          if (bus.stall || r.ctrl_wr) begin
            refuse = 1'b1;
          end else if (wdata_i[`SPFC_GO_SPM]) begin
            unique case (r.last_cmd)
              `SPFC_CMD_WRITE: begin
                refuse = !r.erased_vld || page_of(r.z) != r.erased_page;
              end
              `SPFC_CMD_LOAD: refuse = r.loaded[w];
              default: refuse = 1'b0;
            endcase
            if (!refuse) begin
              n.store_program_instr = 1'b1;
              n.z_out = r.z;
              if (r.last_cmd == `SPFC_CMD_WRITE) begin
                n.z_out = '0;
                n.z_out[WB+PB:WB+1] = page_of(r.z);
                n.loaded = '0;
                n.erased_vld = 1'b0;
              end else if (r.last_cmd == `SPFC_CMD_ERASE) begin
                n.erased_page = page_of(r.z);
                n.erased_vld = 1'b1;
              end else if (r.last_cmd == `SPFC_CMD_LOAD) begin
                n.loaded[w] = 1'b1;
              end
              n.last_cmd = 5'h00;
            end
          end else if (wdata_i[`SPFC_GO_LPM]) begin
            n.load_program_instr = 1'b1;
            n.z_out = r.z;
            n.last_cmd = 5'h00;
          end
        end
        default: refuse = 1'b0;
      endcase
    end
    if (refuse) begin
      n.refused = 1'b1;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign rdata_o = r.rdata;
  assign bus.ctrl_wr = r.ctrl_wr;
  assign bus.ctrl_wdata = r.ctrl_wdata;
  assign bus.store_program_instr = r.store_program_instr;
  assign bus.load_program_instr = r.load_program_instr;
  assign bus.z_ptr = r.z_out;
  assign bus.write_data_pair = r.pair;
endmodule : spfc_host
`default_nettype wire

// file: dv/spfc_sva.sv
/*
 Assertions on the link between the core end and the flash controller end.
 Assumes one clock domain and a synchronous active-low reset.
*/
`timescale 1ns/10ps
`default_nettype none
module spfc_sva #(
  parameter int OP_CYCLES = 8
) (
  input wire logic sys_clk_i, // System clock
  input wire logic rstn_i, // Reset, active low
  input wire logic ctrl_wr, // Control write
  input wire logic [7:0] ctrl_wdata, // Control value
  input wire logic [7:0] ctrl_rdata, // Control image
  input wire logic store_program_instr, // Store request
  input wire logic load_program_instr, // Load request
  input wire logic stall, // Core stall
  input wire logic lpm_valid // Load answer
);
  logic [31:0] stall_cnt;
  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i) begin
      stall_cnt <= 32'h0;
    end else begin
      stall_cnt <= stall ? stall_cnt + 32'h1 : 32'h0;
    end
  end
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rstn_i);
  sequence s_armed_op;
    store_program_instr && !stall && (ctrl_rdata[2:0] == 3'h3 || ctrl_rdata[2:0] == 3'h5);
  endsequence
  // Six quiet cycles leave margin past the four-cycle window
  sequence s_arm_unused;
    ctrl_wr ##1 (!ctrl_wr && !store_program_instr && !load_program_instr) [*6];
  endsequence
  a_rsvd_reads_zero: assert property (ctrl_rdata[7:5] == 3'h0)
    else $error("reserved control bits set");
  a_op_starts_stall: assert property (s_armed_op |=> stall)
    else $error("armed store did not stall");
  a_stall_has_cause: assert property ($rose(stall) |-> $past(store_program_instr) && ($past(ctrl_rdata) & 8'h06) != 8'h00)
    else $error("stall without armed store");
  a_load_no_stall: assert property (store_program_instr && !stall && ctrl_rdata[2:0] == 3'h1 |=> !stall)
    else $error("buffer load stalled core");
  a_arm_held_busy: assert property (stall |-> ctrl_rdata[0] && ctrl_rdata[2:1] != 2'h0)
    else $error("arm dropped during operation");
  a_stall_length: assert property ($fell(stall) |-> stall_cnt == 32'(OP_CYCLES))
    else $error("stall length wrong");
  a_op_end_clears: assert property ($fell(stall) |-> ctrl_rdata == 8'h00)
    else $error("control bits kept after operation");
  a_arm_times_out: assert property (s_arm_unused |-> ctrl_rdata == 8'h00)
    else $error("arm outlived its window");
  a_bad_cmd_ignored: assert property (ctrl_wr && ctrl_rdata == 8'h00 && !(ctrl_wdata[4:0] inside
    {5'h01, 5'h03, 5'h05, 5'h09, 5'h11}) |=> ctrl_rdata == 8'h00)
    else $error("illegal pattern took effect");
  a_load_answered: assert property (load_program_instr && !stall |=> lpm_valid)
    else $error("load request not answered");
endmodule : spfc_sva
`default_nettype wire

// file: dv/self_program_flash_ctrl_test.sv
/*
 Testbench joining core end and controller end, driving the core register port.
 Assumes the register map and command patterns of the shared defines.
*/
`timescale 1ns/10ps
`default_nettype none
`include "spfc_defines.svh"
`define CHK(n, e, a) begin n_checks++; if ((a) !== (e)) begin fails++; \
  $display("[ERR] %s exp %h got %h", n, e, a); end end
module self_program_flash_ctrl_test;
  localparam int PW = 32;
  localparam int OPC = 8;
  logic sys_clk_i, rstn_i, wr, rd, ee_busy, busy;
  logic [2:0] addr;
  logic [15:0] wdata, rdata;
  int fails, n_checks;
  spfc_if link();
  spfc_host #(.PAGE_WORDS(PW), .PAGES(16)) u_spfc_host(.sys_clk_i(sys_clk_i), .rstn_i(rstn_i),
    .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .bus(link.core));
  spfc_device #(.PAGE_WORDS(PW), .PAGES(16), .OP_CYCLES(OPC)) u_spfc_device(.sys_clk_i(sys_clk_i),
    .rstn_i(rstn_i), .bus(link.device), .eeprom_busy_i(ee_busy), .fuse_low_i(8'h5a),
    .fuse_high_i(8'hc3), .lock_bits_i(8'hfc), .busy_o(busy));
  spfc_sva #(.OP_CYCLES(OPC)) u_spfc_sva(.sys_clk_i(sys_clk_i), .rstn_i(rstn_i), .ctrl_wr(link.ctrl_wr),
    .ctrl_wdata(link.ctrl_wdata), .ctrl_rdata(link.ctrl_rdata), .store_program_instr(link.store_program_instr), .load_program_instr(link.load_program_instr),
    .stall(link.stall), .lpm_valid(link.lpm_valid));
  initial begin
    sys_clk_i = 1'b0;
    forever #5 sys_clk_i = ~sys_clk_i;
  end
  function automatic logic [15:0] zaddr(input int p, input int w, input int b);
    return 16'(p * 2 * PW + w * 2 + b);
  endfunction : zaddr
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk_i);
  endtask : cyc
  // Strobe then one idle edge, so back-to-back calls never reassign in one step
  task automatic wreg(input logic [2:0] a, input logic [15:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge sys_clk_i);
    wr <= 1'b0;
    @(posedge sys_clk_i);
  endtask : wreg
  task automatic rreg(input logic [2:0] a, output logic [15:0] v);
    addr <= a;
    rd <= 1'b1;
    @(posedge sys_clk_i);
    rd <= 1'b0;
    #1;
    v = rdata;
    @(posedge sys_clk_i);
  endtask : rreg
  task automatic op(input logic [7:0] c, input logic [15:0] z);
    int i;
    wreg(`SPFC_REG_Z, z);
    wreg(`SPFC_REG_CTRL, {8'h00, c});
    wreg(`SPFC_REG_GO, 16'h0001);
    #1;
    `CHK("busy_start", 1'b1, busy)
    for (i = 0; i < 40 && busy !== 1'b0; i++) begin
      @(posedge sys_clk_i);
      #1;
    end
    `CHK("busy_end", 1'b0, busy)
    `CHK("op_cycles", OPC, i)
    if (i == 40) begin
      finish_test();
    end else begin
      @(posedge sys_clk_i);
    end
  endtask : op
  task automatic load(input int p, input int w, input logic [15:0] d);
    wreg(`SPFC_REG_Z, zaddr(p, w, 0));
    wreg(`SPFC_REG_DATA, d);
    wreg(`SPFC_REG_CTRL, 16'h0001);
    wreg(`SPFC_REG_GO, 16'h0001);
  endtask : load
  task automatic rdbyte(input logic [15:0] z, output logic [7:0] b);
    logic [15:0] v;
    wreg(`SPFC_REG_Z, z);
    wreg(`SPFC_REG_GO, 16'h0002);
    cyc(2);
    rreg(`SPFC_REG_RESULT, v);
    b = v[7:0];
  endtask : rdbyte
  task automatic t_erase_write();
    logic [7:0] b;
    op(8'h03, zaddr(2, 7, 1));
    rdbyte(zaddr(2, 3, 0), b);
    `CHK("erased", 8'hff, b)
    load(2, 3, 16'h1234);
    load(2, 1, 16'habcd);
    op(8'h05, zaddr(2, 0, 0));
    rdbyte(zaddr(2, 3, 0), b);
    `CHK("w3_lo", 8'h34, b)
    rdbyte(zaddr(2, 3, 1), b);
    `CHK("w3_hi", 8'h12, b)
    rdbyte(zaddr(2, 1, 0), b);
    `CHK("w1_lo", 8'hcd, b)
    rdbyte(zaddr(2, 0, 0), b);
    `CHK("w0_lo", 8'hff, b)
  endtask : t_erase_write
  // Mode 3 after-write, 0 clear bit, 1 EEPROM write, 2 system reset
  task automatic t_discard(input int m);
    logic [7:0] b;
    op(8'h03, zaddr(4 + m, 0, 0));
    if (m != 3) load(4 + m, 3, 16'h0000);
    if (m == 0) wreg(`SPFC_REG_CTRL, 16'h0011);
    if (m == 1) begin
      ee_busy <= 1'b1;
      cyc(1);
      ee_busy <= 1'b0;
      cyc(1);
    end
    if (m == 2) begin
      rstn_i <= 1'b0;
      cyc(2);
      rstn_i <= 1'b1;
      cyc(1);
      op(8'h03, zaddr(4 + m, 0, 0));
    end
    op(8'h05, zaddr(4 + m, 0, 0));
    rdbyte(zaddr(4 + m, 3, 0), b);
    `CHK("discarded", 8'hff, b)
  endtask : t_discard
  task automatic t_fuse();
    logic [15:0] v;
    logic [7:0] e [4];
    e = '{8'h5a, 8'hfc, 8'h5a, 8'hc3};
    for (int k = 0; k < 4; k++) begin
      wreg(`SPFC_REG_Z, 16'(k));
      wreg(`SPFC_REG_CTRL, 16'h0009);
      wreg(`SPFC_REG_GO, 16'h0002);
      cyc(2);
      rreg(`SPFC_REG_RESULT, v);
      `CHK("fuse_lock", e[k], v[7:0])
    end
  endtask : t_fuse
  task automatic t_ctrl();
    logic [15:0] v;
    logic [7:0] p [5];
    logic [7:0] e [5];
    p = '{8'he3, 8'h05, 8'h09, 8'h07, 8'h19};
    e = '{8'h03, 8'h05, 8'h09, 8'h00, 8'h00};
    for (int k = 0; k < 5; k++) begin
      wreg(`SPFC_REG_CTRL, {8'h00, p[k]});
      rreg(`SPFC_REG_STATUS, v);
      `CHK("ctrl_armed", {8'h00, e[k]}, v)
      cyc(4);
      rreg(`SPFC_REG_STATUS, v);
      `CHK("ctrl_lapsed", 16'h0000, v)
    end
  endtask : t_ctrl
  // The core end must refuse a write to an unerased page and a second load of one slot
  task automatic t_refuse();
    logic [15:0] v;
    wreg(`SPFC_REG_Z, zaddr(9, 0, 0));
    wreg(`SPFC_REG_CTRL, 16'h0005);
    wreg(`SPFC_REG_GO, 16'h0001);
    cyc(4);
    rreg(`SPFC_REG_STATUS, v);
    `CHK("refuse_write", 16'h0200, v)
    load(9, 0, 16'h0000);
    load(9, 0, 16'h0000);
    cyc(4);
    rreg(`SPFC_REG_STATUS, v);
    `CHK("refuse_reload", 16'h0200, v)
    rreg(`SPFC_REG_STATUS, v);
    `CHK("refuse_clear", 16'h0000, v)
  endtask : t_refuse
  task automatic finish_test();
    $display("checks %0d fails %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : finish_test
  initial begin
    logic [15:0] v;
    rstn_i = 1'b0;
    {wr, rd, ee_busy} = 3'h0;
    addr = 3'h0;
    wdata = 16'h0000;
    repeat (2) @(posedge sys_clk_i);
    rstn_i <= 1'b1;
    @(posedge sys_clk_i);
    rreg(`SPFC_REG_STATUS, v);
    `CHK("status_reset", 16'h0000, v)
    t_ctrl();
    t_erase_write();
    t_discard(3);
    t_discard(0);
    t_discard(1);
    t_discard(2);
    t_fuse();
    t_refuse();
    finish_test();
  end
endmodule : self_program_flash_ctrl_test
`default_nettype wire
